// ===== rtl/mrs_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH
// Summary of operation
// - Chip reset from pin, halted pin, watchdog
// - Watchdog in halt: warm reset, PC/SP only
// - Flags follow cause table; power-up clears both
// - Startup timer holds core 1024 clocks
// - Option load delay skipped on watchdog and wake-event halt wake-ups
// - Chip reset: PC 000H, ints off, inputs
// - Watchdog cleared, counts after master reset
// - Non-warm resets load register default values
// - Data registers keep contents, counts unknown
// - Warm reset clears PC and SP only
// - Halt sets powerdown, clears timeout; clear-instr clears powerdown
// - Halt left by pin, interrupt, port, watchdog
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MRS_OFS_FLAGS      8'h00
`define MRS_OFS_IRQ_STATUS 8'h04
`define MRS_OFS_IRQ_CLEAR  8'h08
`define MRS_OFS_IRQ_ENABLE 8'h0C
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MRS_FLAG_TIMEOUT   0
`define MRS_FLAG_POWERDOWN 1
`define MRS_FLAG_STATE_LO  2
`define MRS_EV_CHIP        0
`define MRS_EV_WARM        1
`define MRS_EV_HALT        2
`define MRS_EV_WAKE        3
// ----------------------------------------------------------------
// Reset values and register defaults
// ----------------------------------------------------------------
`define MRS_IRQ_RESET      4'h0
`define MRS_PCL_DEFAULT    8'h00
`define MRS_PORT_DEFAULT   8'hFF
`define MRS_TIMER0_CONTROL_DEFAULT  8'h08
`define MRS_CONVERTER_CONTROL_DEFAULT   8'h40
`define MRS_AMPLIFIER_CONTROL_DEFAULT   8'h08
`define MRS_INTERRUPT_CONTROL0_DEFAULT  8'h00
// ----------------------------------------------------------------
// Timing counts (system clock periods)
// ----------------------------------------------------------------
`define MRS_SST_CYCLES     11'd1024
`define MRS_OPT_CYCLES     16
`endif

// ===== rtl/mrs_pkg.sv
// Types shared by the reset sequencer
package mrs_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		MRS_OPTION_LOAD,
		MRS_STARTUP,
		MRS_RUN,
		MRS_HALT
	} mrs_state_e;
	// Event vector width of the interrupt registers
	typedef logic [3:0] mrs_event_t;
endpackage

// ===== rtl/mrs_reset_sequencer.sv
// Reset sequencer: cause tracking, startup delays, register defaults and AHB-Lite status port
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mrs_regs.svh"
module mrs_reset_sequencer #(
	parameter int OPT_LOAD_CYCLES = `MRS_OPT_CYCLES
) (
	// System clock and power-up reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// External reset pin, asynchronous
	input  wire logic        external_reset_pin_n,
	// Core events, same clock
	input  wire logic        halt_exec,
	input  wire logic        watchdog_clear_instruction,
	input  wire logic        watchdog_overflow,
	input  wire logic        wake_event,
	// Core control
	output logic             core_reset_n,
	output logic             core_hold,
	output logic             warm_reset,
	output logic             load_defaults,
	output logic             halted,
	output logic             watchdog_clear,
	output logic             watchdog_run,
	// Register default values
	output logic      [7:0]  program_counter_low_default,
	output logic      [7:0]  port_default,
	output logic      [7:0]  timer0_control_default,
	output logic      [7:0]  converter_control_default,
	output logic      [7:0]  amplifier_control_default,
	output logic      [7:0]  interrupt_control0_default,
	// Interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [10:0] OPT_LAST = 11'(OPT_LOAD_CYCLES - 1); // Last option-load count
	localparam logic [10:0] SST_LAST = `MRS_SST_CYCLES - 11'd1;   // Last startup count

	logic                   pin_meta_q;      // First sync stage
	logic                   pin_sync_q;      // Synchronised pin, low = reset
	mrs_pkg::mrs_state_e    state_q;         // Sequencer state
	mrs_pkg::mrs_state_e    state_d;         // Next state
	logic [10:0]            cnt_q;           // Delay counter
	logic [10:0]            cnt_d;           // Next count
	logic                   chip_q;          // Current delay belongs to a chip reset
	logic                   chip_d;          // Next chip marker
	logic                   timeout_q;       // Watchdog timeout flag
	logic                   powerdown_q;     // Powerdown flag
	logic                   warm_q;          // Warm reset pulse
	mrs_pkg::mrs_event_t    ev;              // Events this cycle
	mrs_pkg::mrs_event_t    irq_st_q;        // Sticky status
	mrs_pkg::mrs_event_t    irq_en_q;        // Enable mask
	mrs_pkg::mrs_event_t    irq_clr;         // Clear strobe
	logic                   wr_pend_q;       // Write data phase pending
	logic [7:0]             wr_addr_q;       // Write address
	logic [31:0]            hrdata_q;        // Read data
	logic                   addr_ok;         // Valid address phase
	logic                   pin_low;         // Reset pin asserted
	logic                   run_s;           // In normal run
	logic                   halt_s;          // In halt
	logic [10:0]            hold_len_q;      // Cycles held so far in the current stall

	assign pin_low = !pin_sync_q;
	assign run_s   = (state_q == mrs_pkg::MRS_RUN);
	assign halt_s  = (state_q == mrs_pkg::MRS_HALT);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// Two stages; only the second is read by any logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= external_reset_pin_n;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Next state; pin wins over watchdog, watchdog over halt and wake
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		chip_d  = chip_q;
		case (state_q)
			mrs_pkg::MRS_OPTION_LOAD: begin
				// Held at zero while the pin stays low
				if (pin_low) begin
					cnt_d = '0;
				end else if (cnt_q == OPT_LAST) begin
					state_d = mrs_pkg::MRS_STARTUP;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q + 11'd1;
				end
			end
			mrs_pkg::MRS_STARTUP: begin
				if (pin_low) begin
					state_d = mrs_pkg::MRS_OPTION_LOAD;
					cnt_d   = '0;
					chip_d  = 1'b1;
				end else if (cnt_q == SST_LAST) begin
					state_d = mrs_pkg::MRS_RUN;
					cnt_d   = '0;
					chip_d  = 1'b0;
				end else begin
					cnt_d = cnt_q + 11'd1;
				end
			end
			mrs_pkg::MRS_RUN: begin
				// Pin or watchdog: full chip reset with option load
				if (pin_low || watchdog_overflow) begin
					state_d = mrs_pkg::MRS_OPTION_LOAD;
					cnt_d   = '0;
					chip_d  = 1'b1;
				end else if (halt_exec) begin
					state_d = mrs_pkg::MRS_HALT;
				end
			end
			mrs_pkg::MRS_HALT: begin
				if (pin_low) begin
					state_d = mrs_pkg::MRS_OPTION_LOAD;
					cnt_d   = '0;
					chip_d  = 1'b1;
				end else if (watchdog_overflow || wake_event) begin
					// No option load on a watchdog or wake-event halt wake-up
					state_d = mrs_pkg::MRS_STARTUP;
					cnt_d   = '0;
				end
			end
			default: begin
				state_d = mrs_pkg::MRS_OPTION_LOAD;
				cnt_d   = '0;
				chip_d  = 1'b1;
			end
		endcase
	end

	// State registers; power-up starts in option load
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= mrs_pkg::MRS_OPTION_LOAD;
			cnt_q   <= '0;
			chip_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			chip_q  <= chip_d;
		end
	end

	// Warm reset pulse: watchdog overflow while halted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			warm_q <= 1'b0;
		end else begin
			warm_q <= halt_s && !pin_low && watchdog_overflow;
		end
	end

	// ----------------------------------------------------------------
	// Cause flags
	// ----------------------------------------------------------------
	// Power-up clears both; pin in run leaves them as they are
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_q   <= 1'b0;
			powerdown_q <= 1'b0;
		end else if (halt_s && pin_low) begin
			timeout_q   <= 1'b0;
			powerdown_q <= 1'b1;
		end else if (halt_s && watchdog_overflow) begin
			timeout_q   <= 1'b1;
			powerdown_q <= 1'b1;
		end else if (run_s && !pin_low && watchdog_overflow) begin
			timeout_q   <= 1'b1;
		end else if (run_s && !pin_low && halt_exec) begin
			timeout_q   <= 1'b0;
			powerdown_q <= 1'b1;
		end else if (run_s && !pin_low && watchdog_clear_instruction) begin
			powerdown_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Core control outputs
	// ----------------------------------------------------------------
	// Reset held through option load and the startup count that follows it
	assign core_reset_n   = !(state_q == mrs_pkg::MRS_OPTION_LOAD ||
	                          (state_q == mrs_pkg::MRS_STARTUP && chip_q));
	// Wake-up delay stalls the core without resetting it
	assign core_hold      = (state_q == mrs_pkg::MRS_STARTUP) && !chip_q;
	assign warm_reset     = warm_q;
	// Defaults apply on chip resets only; the warm reset never loads them.
	// Accumulator and pointers get no strobe, so they keep their contents.
	assign load_defaults  = !core_reset_n;
	assign halted         = halt_s;
	// Watchdog held clear during reset, free once master reset ends
	assign watchdog_clear = !core_reset_n;
	assign watchdog_run   = core_reset_n;

	// Program counter to 000H, interrupts and timers off, ports input
	assign program_counter_low_default = `MRS_PCL_DEFAULT;
	assign port_default                = `MRS_PORT_DEFAULT;
	assign timer0_control_default      = `MRS_TIMER0_CONTROL_DEFAULT;
	assign converter_control_default   = `MRS_CONVERTER_CONTROL_DEFAULT;
	assign amplifier_control_default   = `MRS_AMPLIFIER_CONTROL_DEFAULT;
	assign interrupt_control0_default  = `MRS_INTERRUPT_CONTROL0_DEFAULT;

	// ----------------------------------------------------------------
	// Interrupt logic
	// ----------------------------------------------------------------
	// Events observed on state transitions
	always_comb begin
		ev                = '0;
		ev[`MRS_EV_CHIP]  = (state_d == mrs_pkg::MRS_OPTION_LOAD) &&
		                    (state_q != mrs_pkg::MRS_OPTION_LOAD);
		ev[`MRS_EV_WARM]  = halt_s && !pin_low && watchdog_overflow;
		ev[`MRS_EV_HALT]  = (state_d == mrs_pkg::MRS_HALT) && run_s;
		ev[`MRS_EV_WAKE]  = halt_s && (state_d == mrs_pkg::MRS_STARTUP);
	end

	// Clear strobe from a write to the clear register
	assign irq_clr = (wr_pend_q && wr_addr_q == `MRS_OFS_IRQ_CLEAR) ? hwdata[3:0] : 4'h0;

	// Sticky status; an event in the clearing cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_st_q <= `MRS_IRQ_RESET;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | ev;
		end
	end

	// Enable mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_q <= `MRS_IRQ_RESET;
		end else if (wr_pend_q && wr_addr_q == `MRS_OFS_IRQ_ENABLE) begin
			irq_en_q <= hwdata[3:0];
		end
	end

	assign irq = |(irq_st_q & irq_en_q);

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel && htrans[1] && hready;
	assign hrdata    = hrdata_q;

	// Write address captured in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			wr_addr_q <= haddr;
		end
	end

	// Read data registered in the address phase; unmapped reads return zero.
	// Firmware tells the reset cause from the two flags here.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (addr_ok && !hwrite) begin
			case (haddr)
				`MRS_OFS_FLAGS:      hrdata_q <= {28'h000_0000, 2'(state_q), powerdown_q, timeout_q};
				`MRS_OFS_IRQ_STATUS: hrdata_q <= {28'h000_0000, irq_st_q};
				`MRS_OFS_IRQ_ENABLE: hrdata_q <= {28'h000_0000, irq_en_q};
				default:             hrdata_q <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Stall length counter; a long delay chain would be far too slow to check
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_len_q <= '0;
		end else if (core_hold) begin
			hold_len_q <= hold_len_q + 11'd1;
		end else begin
			hold_len_q <= '0;
		end
	end

	halt_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run_s && pin_sync_q && !watchdog_overflow && halt_exec |=> powerdown_q && !timeout_q && halted)
		else $error("halt entry flags wrong");

	warm_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
		halt_s && pin_sync_q && watchdog_overflow |=> timeout_q && powerdown_q && warm_reset)
		else $error("watchdog halt wake flags wrong");

	pin_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		halt_s && pin_low |=> !timeout_q && powerdown_q && !core_reset_n)
		else $error("pin halt wake flags wrong");

	pin_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run_s && pin_low |=> $stable(timeout_q) && $stable(powerdown_q))
		else $error("pin reset in run changed flags");

	sst_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(run_s) |-> $past(cnt_q) == SST_LAST && $past(state_q) == mrs_pkg::MRS_STARTUP)
		else $error("startup delay length wrong");

	warm_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		warm_reset |-> core_reset_n && !load_defaults && core_hold)
		else $error("warm reset disturbed core state");

	release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(core_reset_n) |-> $past(cnt_q) == SST_LAST && $past(pin_sync_q))
		else $error("reset released early");

	wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
		halt_s && pin_sync_q && wake_event |=> core_hold && hold_len_q == 11'd0)
		else $error("wake-up did not start the delay");

	hold_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(core_hold) && run_s |-> hold_len_q == `MRS_SST_CYCLES)
		else $error("wake-up delay length wrong");

	wdt_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run_s && pin_sync_q && watchdog_overflow |=> watchdog_clear && !watchdog_run)
		else $error("watchdog not cleared on chip reset");

endmodule

// ===== verif/mrs_pin_drv.sv
// Board-side model that pulls the external reset pin low on request
`timescale 1ns/1ps
module mrs_pin_drv (
	// Clock and request from the bench
	input  wire logic       hclk,
	input  wire logic       go,
	input  wire logic [7:0] len,
	// Reset pin, pulled up on the board
	output logic            external_reset_pin_n
);
	// ----------------------------------------------------------------
	// Pin driver
	// ----------------------------------------------------------------
	int left; // Low cycles still to go
	initial begin
		left = 0;
		external_reset_pin_n = 1'b1;
	end
	// Pin changes only just after a rising edge, so the synchroniser sees clean levels
	always @(posedge hclk) begin
		if (go) begin
			left <= len;
			external_reset_pin_n <= 1'b0;
		end else if (left > 1) begin
			left <= left - 1;
		end else begin
			// Pull-up brings the pin back high once released
			left <= 0;
			external_reset_pin_n <= 1'b1;
		end
	end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "mrs_regs.svh"
`define CHK(nm, ex, sn) begin samples_checked++; if ((sn) !== (ex)) begin errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, ex, sn); end end
module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int OPT = 2; // Short option load keeps the run brief
	localparam int L   = 1024 + OPT;
	logic        hclk, hresetn, hsel, hwrite, pgo;
	logic        halt_exec, watchdog_clear_instruction, watchdog_overflow, wake_event;
	logic [7:0]  haddr, plen;
	logic [1:0]  htrans, fl;
	logic [31:0] hwdata, r;
	logic [3:0]  msk;
	wire logic   hready, hreadyout, hresp, pin_n, core_reset_n, core_hold, warm_reset;
	wire logic   load_defaults, halted, watchdog_clear, watchdog_run, irq;
	wire logic [31:0] hrdata;
	wire logic [7:0]  pcl_d, port_d, tmr_d, conv_d, amp_d, intc_d;
	int          errors, samples_checked, cyc, lo, hd, wr;
	assign hready = hreadyout; // Single slave drives the bus ready
	mrs_reset_sequencer #(.OPT_LOAD_CYCLES(OPT)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_reset_pin_n(pin_n),
		.halt_exec(halt_exec), .watchdog_clear_instruction(watchdog_clear_instruction),
		.watchdog_overflow(watchdog_overflow), .wake_event(wake_event), .core_reset_n(core_reset_n),
		.core_hold(core_hold), .warm_reset(warm_reset), .load_defaults(load_defaults), .halted(halted),
		.watchdog_clear(watchdog_clear), .watchdog_run(watchdog_run), .program_counter_low_default(pcl_d),
		.port_default(port_d), .timer0_control_default(tmr_d), .converter_control_default(conv_d),
		.amplifier_control_default(amp_d), .interrupt_control0_default(intc_d), .irq(irq));
	mrs_pin_drv pin_u (.hclk(hclk), .go(pgo), .len(plen), .external_reset_pin_n(pin_n));
	// ----------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------
	initial hclk = 1'b0;
	always #25 hclk = ~hclk;
	// Ceiling well above the six reset sequences the run holds
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			results();
		end
	end
	// Flag pair {powerdown, timeout} after each cause
	function automatic logic [1:0] next_flags(input logic [1:0] f, input int c);
		case (c)
			1, 4:    return 2'b10;
			2:       return {f[1], 1'b1};
			3:       return 2'b11;
			5:       return {1'b0, f[0]};
			default: return f;
		endcase
	endfunction
	// One single AHB-Lite transfer, whole word
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	// Cause codes: 0/1 pin in run/halt, 2/3 watchdog in run/halt, 4 halt, 5 clear, 6 wake
	task automatic ev(input int c);
		repeat ($urandom_range(0, 3)) @(posedge hclk);
		@(posedge hclk);
		case (c)
			0, 1:    begin plen <= 8'($urandom_range(3, 10)); pgo <= 1'b1; end
			2, 3:    watchdog_overflow <= 1'b1;
			4:       halt_exec <= 1'b1;
			5:       watchdog_clear_instruction <= 1'b1;
			default: wake_event <= 1'b1;
		endcase
		@(posedge hclk);
		{pgo, watchdog_overflow, halt_exec, watchdog_clear_instruction, wake_event} <= 5'h00;
		fl = next_flags(fl, c);
	endtask
	// Counts reset-low, hold and warm pulse cycles of one sequence
	task automatic meas();
		int k;
		k = 0;
		lo = 0;
		hd = 0;
		wr = 0;
		@(negedge hclk);
		while (core_reset_n === 1'b1 && core_hold !== 1'b1 && k < 16) begin k++; @(negedge hclk); end
		while ((core_reset_n !== 1'b1 || core_hold !== 1'b0) && lo + hd < 3000) begin
			if (core_reset_n === 1'b0 && lo == 0) begin
				`CHK("load_defaults", 1'b1, load_defaults)
				`CHK("watchdog_clear", 1'b1, watchdog_clear)
			end
			lo += (core_reset_n === 1'b0);
			hd += (core_hold === 1'b1);
			wr += (warm_reset === 1'b1);
			@(negedge hclk);
		end
		`CHK("watchdog_run", 1'b1, watchdog_run)
	endtask
	// Firmware reads the cause flags
	task automatic fchk();
		bus(`MRS_OFS_FLAGS, 1'b0, 32'h0000_0000, r);
		`CHK("flags", fl, r[1:0])
		`CHK("hresp", 1'b0, hresp)
		`CHK("hreadyout", 1'b1, hreadyout)
	endtask
	task automatic results();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, pgo, halt_exec, watchdog_clear_instruction, watchdog_overflow} = 7'h00;
		{wake_event, haddr, htrans, hwdata, plen} = 51'h0;
		{errors, samples_checked, cyc} = 0;
		fl = 2'b00;
		r = $urandom(30294);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		meas();
		`CHK("powerup_len", 1'b1, lo >= L && lo <= L + 4)
		`CHK("defaults", 48'h00ff_0840_0800, {pcl_d, port_d, tmr_d, conv_d, amp_d, intc_d})
		fchk();
		ev(4);
		@(negedge hclk);
		`CHK("halted", 1'b1, halted)
		fchk();
		ev(6);
		meas();
		`CHK("wake_cnt", 2051, {hd, lo, wr} == {32'd1024, 32'd0, 32'd0} ? 2051 : hd)
		fchk();
		ev(5);
		fchk();
		ev(2);
		meas();
		`CHK("wdt_len", L, lo)
		fchk();
		ev(4);
		ev(3);
		meas();
		`CHK("warm_hold", 1024, hd)
		`CHK("warm_pulse", 1, wr)
		`CHK("warm_nochip", 0, lo)
		fchk();
		ev(0);
		meas();
		`CHK("pin_len", 1'b1, lo >= L && lo <= L + 14)
		fchk();
		ev(4);
		ev(1);
		meas();
		`CHK("pin_halt_len", 1'b1, lo >= L && lo <= L + 14)
		fchk();
		// Interrupt: enable, status, mask, clear, unmapped and read-only
		msk = 4'($urandom_range(1, 15));
		bus(`MRS_OFS_IRQ_ENABLE, 1'b1, {28'h0, msk}, r);
		bus(`MRS_OFS_IRQ_ENABLE, 1'b0, 32'h0000_0000, r);
		`CHK("irq_en", {28'h0, msk}, r)
		bus(`MRS_OFS_IRQ_STATUS, 1'b0, 32'h0000_0000, r);
		`CHK("irq_status", 32'h0000_000f, r)
		`CHK("irq_on", 1'b1, irq)
		bus(`MRS_OFS_IRQ_ENABLE, 1'b1, 32'h0000_0000, r);
		@(negedge hclk);
		`CHK("irq_masked", 1'b0, irq)
		bus(`MRS_OFS_IRQ_ENABLE, 1'b1, {28'h0, msk}, r);
		bus(`MRS_OFS_IRQ_CLEAR, 1'b1, 32'h0000_000f, r);
		bus(`MRS_OFS_IRQ_STATUS, 1'b0, 32'h0000_0000, r);
		`CHK("irq_clr", 32'h0000_0000, r)
		`CHK("irq_off", 1'b0, irq)
		bus(8'h10, 1'b0, 32'h0000_0000, r);
		`CHK("unmapped", 32'h0000_0000, r)
		bus(`MRS_OFS_FLAGS, 1'b1, 32'hffff_ffff, r);
		fchk();
		results();
	end
endmodule
